// file: design/polling_motion_wake_control.sv
// Polling, low-power and motion wake control with serial link and APB registers
// Notes on behaviour
// - Serial commands switch active and low-power modes
// - Frame carries lock flag; host trusts locked only
// - Store-reference copies current angle into backed register
// - Retained settings survive main supply off
// - Compare angle with reference after 250us
// - Difference above threshold raises motion interrupt
// - On-time counts only after supply passes POR
// - Gain value 0 for too strong field
// - Gain value 3F for weak or missing field
// - Angle output continues while gain saturated
// - Trim reload is command code 19
// - Store-reference is code 3; none means wake
// - Backed copy only when wake-enable fuse set
// - Wake pin low about 10us, then released
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module polling_motion_wake_control
    import wake_pkg::*;
#(
    parameter int ON_CYCLES_P = wake_pkg::ON_CYCLES
) (
    input wire logic clk_in,                          // 50 MHz clock
    input wire logic resetn_in,                       // Low-power supply reset
    input wire logic psel,                            // APB select
    input wire logic penable,                         // APB enable
    input wire logic pwrite,                          // APB direction
    input wire logic [7:0] paddr,                     // APB byte address
    input wire logic [31:0] pwdata,                   // APB write data
    output logic [31:0] prdata,                       // APB read data
    output logic pready,                              // APB ready
    output logic pslverr,                             // APB error
    input wire logic sclk_in,                         // Serial link clock
    input wire logic csn_in,                          // Serial frame select
    input wire logic sdi_in,                          // Serial data from host
    output logic sdo_out,                             // Serial data to host
    output logic sdo_oe_out,                          // Serial data drive enable
    input wire logic vdd_por_in,                      // Main supply above POR level
    input wire logic [wake_pkg::ANGLE_W-1:0] angle_in, // Measured angle
    input wire logic [wake_pkg::AGC_W-1:0] agc_in,    // Raw gain value
    input wire logic field_strong_in,                 // Field too strong
    input wire logic field_weak_in,                   // Field too weak or absent
    input wire logic lock_in,                         // Converter locked
    input wire logic [wake_pkg::TRIM_W-1:0] fuse_in,  // Fuse trim contents
    input wire logic wake_pin_in,                     // Wake pin level
    output logic wake_pin_out,                        // Wake pin value, always low
    output logic wake_pin_oe_out,                     // Wake pin pull-down enable
    output logic low_power_out,                       // Low-power mode active
    output logic [wake_pkg::AGC_W-1:0] agc_out,       // Reported gain value
    output logic irq_out                              // Level interrupt
);
    import wake_pkg::*;

    logic rst_meta_r, rst_n;
    logic [SYNC_W-1:0] sync_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Idle-high pins enter inverted so the synchroniser reset matches idle
    pin_sync #(.W(SYNC_W)) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .d_in({~wake_pin_in, vdd_por_in, sdi_in, ~csn_in, sclk_in}),
        .q_out(sync_q)
    );

    logic sclk_s, csn_s, din_s, por_s, wake_s;
    assign sclk_s = sync_q[S_SCLK];
    assign csn_s = ~sync_q[S_CSN];
    assign din_s = sync_q[S_DIN];
    assign por_s = sync_q[S_POR];
    assign wake_s = ~sync_q[S_WAKE];

    // Gain saturation codes; angle path untouched
    logic [AGC_W-1:0] agc_rep;
    always_comb begin
        if (field_strong_in) begin
            agc_rep = AGC_MIN;
        end else if (field_weak_in) begin
            agc_rep = AGC_MAX;
        end else begin
            agc_rep = agc_in;
        end
    end

    // Serial link: shift in on rising edge, update output on falling edge
    logic sclk_d_r, sclk_d_nxt;
    logic [BITCNT_W-1:0] bitcnt_r, bitcnt_nxt;
    logic [FRAME_BITS-1:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic sdo_r, sdo_nxt;
    logic cmd_stb;
    logic [CMD_W-1:0] cmd_code;
    logic [FRAME_BITS-1:0] frame_word;
    logic csn_d_r, csn_d_nxt;

    // Lock flag travels in the frame every time
    assign frame_word = {angle_in, agc_rep, lock_in, low_power_out};

    always_comb begin
        sclk_d_nxt = sclk_s;
        csn_d_nxt = csn_s;
        bitcnt_nxt = bitcnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        sdo_nxt = sdo_r;
        cmd_stb = 1'b0;
        if (csn_s) begin
            bitcnt_nxt = '0;
            tx_nxt = frame_word;
            sdo_nxt = frame_word[FRAME_BITS-1];
            // Frame ends: only a full frame is taken as a command
            if (!csn_d_r && bitcnt_r == BITCNT_W'(FRAME_BITS)) begin
                cmd_stb = 1'b1;
            end
        end else begin
            if (sclk_s && !sclk_d_r) begin
                rx_nxt = {rx_r[FRAME_BITS-2:0], din_s};
                if (bitcnt_r != BITCNT_W'(FRAME_BITS)) begin
                    bitcnt_nxt = bitcnt_r + 1'b1;
                end
                tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
            end
            if (!sclk_s && sclk_d_r) begin
                sdo_nxt = tx_r[FRAME_BITS-1];
            end
        end
    end
    assign cmd_code = rx_r[CMD_LSB +: CMD_W];

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            csn_d_r <= 1'b1;
            bitcnt_r <= '0;
            rx_r <= '0;
            tx_r <= '0;
            sdo_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_d_nxt;
            csn_d_r <= csn_d_nxt;
            bitcnt_r <= bitcnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            sdo_r <= sdo_nxt;
        end
    end
    assign sdo_out = sdo_r;
    assign sdo_oe_out = !csn_s;

    // Backed state: reset only with the low-power supply, kept across VDD loss
    logic [ANGLE_W-1:0] ref_r, ref_nxt, thr_r, thr_nxt;
    logic [TRIM_W-1:0] trim_r, trim_nxt;
    logic ref_valid_r, ref_valid_nxt;
    logic wake_en;
    assign wake_en = trim_r[TRIM_WAKE_EN_BIT];

    always_comb begin
        ref_nxt = ref_r;
        thr_nxt = thr_r;
        trim_nxt = trim_r;
        ref_valid_nxt = ref_valid_r;
        if (cmd_stb && por_s) begin
            case (cmd_code)
                CMD_TRIM_RELOAD: trim_nxt = fuse_in;
                CMD_STORE_REF: begin
                    if (wake_en) begin
                        ref_nxt = angle_in;
                        ref_valid_nxt = 1'b1;
                    end
                end
                CMD_CUST_WRITE: begin
                    if (wake_en) begin
                        thr_nxt = rx_r[ANGLE_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_r <= '0;
            thr_r <= '0;
            trim_r <= '0;
            ref_valid_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
            thr_r <= thr_nxt;
            trim_r <= trim_nxt;
            ref_valid_r <= ref_valid_nxt;
        end
    end

    // Power phase sequencer; core state cleared whenever VDD is below POR
    phase_t phase_r, phase_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic low_power_r, low_power_nxt;
    logic [ANGLE_W-1:0] diff, mag;
    logic cfg_cmp_r;
    logic wake_ev;

    assign diff = angle_in - ref_r;
    assign mag = diff[ANGLE_W-1] ? ANGLE_W'(-diff) : diff;

    always_comb begin
        phase_nxt = phase_r;
        cnt_nxt = cnt_r;
        low_power_nxt = low_power_r;
        wake_ev = 1'b0;
        if (cmd_stb && cmd_code == CMD_LOW_POWER) begin
            low_power_nxt = 1'b1;
        end else if (cmd_stb && cmd_code == CMD_ACTIVE) begin
            low_power_nxt = 1'b0;
        end
        case (phase_r)
            ST_OFF: begin
                cnt_nxt = '0;
                if (por_s) begin
                    phase_nxt = ST_ON_WAIT;
                end
            end
            ST_ON_WAIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(ON_CYCLES_P - 1)) begin
                    cnt_nxt = '0;
                    phase_nxt = ST_COMPARE;
                end
            end
            ST_COMPARE: begin
                // With compare and wake enable set, no reference makes every startup wake
                if (cfg_cmp_r && wake_en && (!ref_valid_r || mag > thr_r)) begin
                    phase_nxt = ST_WAKE;
                    wake_ev = 1'b1;
                end else begin
                    phase_nxt = ST_RUN;
                end
            end
            ST_WAKE: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(WAKE_CYCLES - 1)) begin
                    cnt_nxt = '0;
                    phase_nxt = ST_RUN;
                end
            end
            ST_RUN: cnt_nxt = '0;
            default: phase_nxt = ST_OFF;
        endcase
        if (!por_s) begin
            phase_nxt = ST_OFF;
            cnt_nxt = '0;
            low_power_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= ST_OFF;
            cnt_r <= '0;
            low_power_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            low_power_r <= low_power_nxt;
        end
    end

    // Open drain: only ever pulls low, released otherwise
    assign wake_pin_out = 1'b0;
    assign wake_pin_oe_out = (phase_r == ST_WAKE);
    assign low_power_out = low_power_r;

    logic [AGC_W-1:0] agc_r;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            agc_r <= '0;
        end else begin
            agc_r <= agc_rep;
        end
    end
    assign agc_out = agc_r;

    // APB registers, zero wait states
    logic [EV_W-1:0] status_r, status_nxt, mask_r, mask_nxt, events;
    logic cfg_cmp_nxt;
    logic lock_d_r;
    logic wr_en, rd_en, addr_ok;
    logic [31:0] rdata_nxt, prdata_r;
    logic slverr_nxt, slverr_r;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign events = {lock_in && !lock_d_r, cmd_stb, wake_ev};
    assign addr_ok = (paddr == OFF_STATUS) || (paddr == OFF_MASK) || (paddr == OFF_STATE)
                     || (paddr == OFF_CFG) || (paddr == OFF_REF);

    always_comb begin
        mask_nxt = mask_r;
        cfg_cmp_nxt = cfg_cmp_r;
        status_nxt = status_r;
        rdata_nxt = prdata_r;
        slverr_nxt = 1'b0;
        if (wr_en && paddr == OFF_STATUS) begin
            status_nxt = status_r & ~pwdata[EV_W-1:0];
        end
        // Set beats a clear in the same cycle
        status_nxt = status_nxt | events;
        if (wr_en && paddr == OFF_MASK) begin
            mask_nxt = pwdata[EV_W-1:0];
        end
        if (wr_en && paddr == OFF_CFG) begin
            cfg_cmp_nxt = pwdata[0];
        end
        if (psel && !penable) begin
            rdata_nxt = '0;
            slverr_nxt = !addr_ok;
        end
        if (rd_en) begin
            case (paddr)
                OFF_STATUS: rdata_nxt = {29'h0000000, status_r};
                OFF_MASK: rdata_nxt = {29'h0000000, mask_r};
                OFF_STATE: rdata_nxt = {7'h00, wake_s, ref_valid_r, wake_en, low_power_r, lock_in,
                                         agc_rep, angle_in, 3'h0, phase_r};
                OFF_CFG: rdata_nxt = {31'h00000000, cfg_cmp_r};
                OFF_REF: rdata_nxt = {7'h00, trim_r, thr_r, ref_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
            mask_r <= '0;
            cfg_cmp_r <= CFG_RESET;
            lock_d_r <= 1'b0;
            prdata_r <= '0;
            slverr_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            cfg_cmp_r <= cfg_cmp_nxt;
            lock_d_r <= lock_in;
            prdata_r <= rdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    // Data is prepared in setup, so the access phase completes at once
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = slverr_r && psel && penable;
    assign irq_out = |(status_r & mask_r);
endmodule : polling_motion_wake_control

// file: design/wake_pkg.sv
// Shared constants for the polling motion wake control block
package wake_pkg;
    localparam int CLK_MHZ = 50;
    localparam int T_ON_US = 250;
    localparam int T_WAKE_US = 10;
    localparam int ON_CYCLES = T_ON_US * CLK_MHZ;
    localparam int WAKE_CYCLES = T_WAKE_US * CLK_MHZ;
    localparam int CNT_W = 16;

    localparam int ANGLE_W = 8;
    localparam int AGC_W = 6;
    localparam int TRIM_W = 9;
    localparam int TRIM_WAKE_EN_BIT = 8;
    localparam logic [AGC_W-1:0] AGC_MIN = 6'h00;
    localparam logic [AGC_W-1:0] AGC_MAX = 6'h3F;

    localparam int FRAME_BITS = 16;
    localparam int BITCNT_W = 5;
    localparam int CMD_W = 5;
    localparam int CMD_LSB = 11;
    localparam logic [CMD_W-1:0] CMD_STORE_REF = 5'h03;
    localparam logic [CMD_W-1:0] CMD_TRIM_RELOAD = 5'h13;
    localparam logic [CMD_W-1:0] CMD_CUST_WRITE = 5'h17;
    localparam logic [CMD_W-1:0] CMD_LOW_POWER = 5'h08;
    localparam logic [CMD_W-1:0] CMD_ACTIVE = 5'h09;

    localparam int SYNC_W = 5;
    localparam int S_SCLK = 0;
    localparam int S_CSN = 1;
    localparam int S_DIN = 2;
    localparam int S_POR = 3;
    localparam int S_WAKE = 4;

    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_STATE = 8'h08;
    localparam logic [7:0] OFF_CFG = 8'h0C;
    localparam logic [7:0] OFF_REF = 8'h10;
    localparam int EV_W = 3;
    localparam int EV_WAKE = 0;
    localparam int EV_CMD = 1;
    localparam int EV_LOCK = 2;
    localparam logic CFG_RESET = 1'b1;

    typedef enum logic [2:0] {ST_OFF, ST_ON_WAIT, ST_COMPARE, ST_WAKE, ST_RUN} phase_t;
endpackage : wake_pkg

// file: design/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,            // System clock
    input wire logic rst_n_in,          // Synchronised reset
    input wire logic [W-1:0] d_in,      // Asynchronous inputs
    output logic [W-1:0] q_out          // Filtered, synchronous
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // Change accepted only once stages two and three agree
            always_comb begin
                q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;
endmodule : pin_sync

// file: testbench/wake_ctl_props.sv
// Port assertions for the polling motion wake control block
`timescale 1ns/100ps
module wake_ctl_props
    import wake_pkg::*;
#(
    parameter int ON_CYCLES_P = wake_pkg::ON_CYCLES
) (
    input wire logic clk_in, // Clock
    input wire logic resetn_in, // Reset
    input wire logic psel, // Select
    input wire logic pwrite, // Write
    input wire logic csn_in, // Frame select
    input wire logic vdd_por_in, // Supply good
    input wire logic [wake_pkg::AGC_W-1:0] agc_in, // Raw gain
    input wire logic field_strong_in, // Strong field
    input wire logic field_weak_in, // Weak field
    input wire logic wake_pin_out, // Wake value
    input wire logic wake_pin_oe_out, // Wake drive
    input wire logic sdo_oe_out, // Data drive
    input wire logic low_power_out, // Low power
    input wire logic [wake_pkg::AGC_W-1:0] agc_out, // Gain out
    input wire logic irq_out // Interrupt
);
    logic [CNT_W-1:0] wide_r, wide_nxt, up_r, up_nxt;
    // Pulse length so far, and supply-good time saturating
    always_comb begin
        wide_nxt = wake_pin_oe_out ? wide_r + 1'b1 : '0;
        up_nxt = !vdd_por_in ? '0 : ((&up_r) ? up_r : up_r + 1'b1);
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wide_r <= '0;
            up_r <= '0;
        end else begin
            wide_r <= wide_nxt;
            up_r <= up_nxt;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    property p_irq_fall; $fell(irq_out) |-> $past(psel) && $past(pwrite); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
    property p_wake_len; $fell(wake_pin_oe_out) |-> wide_r == WAKE_CYCLES; endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake pulse length wrong");
    property p_wake_low; wake_pin_out == 1'b0; endproperty
    a_wake_low: assert property (p_wake_low) else $error("wake pin driven high");
    property p_wake_late; $rose(wake_pin_oe_out) |-> up_r > ON_CYCLES_P; endproperty
    a_wake_late: assert property (p_wake_late) else $error("wake before on-time");
    // Settling after reset: output flop lags the reset release
    property p_agc_low; field_strong_in && !field_weak_in && $past(resetn_in, 3) |=> agc_out == AGC_MIN; endproperty
    a_agc_low: assert property (p_agc_low) else $error("gain not zero for strong field");
    property p_agc_high; field_weak_in && !field_strong_in && $past(resetn_in, 3) |=> agc_out == AGC_MAX; endproperty
    a_agc_high: assert property (p_agc_high) else $error("gain not full for weak field");
    property p_agc_pass; !field_weak_in && !field_strong_in && $past(resetn_in, 3) |=> agc_out == $past(agc_in);
    endproperty
    a_agc_pass: assert property (p_agc_pass) else $error("gain not passed through");
    property p_lp_cmd; $rose(low_power_out) |-> csn_in; endproperty
    a_lp_cmd: assert property (p_lp_cmd) else $error("low power entered inside a frame");
    property p_sdo_rel; $changed(csn_in) |-> ##[1:6] (sdo_oe_out != csn_in); endproperty
    a_sdo_rel: assert property (p_sdo_rel) else $error("data drive does not follow frame select");
    c_wake: cover property ($rose(wake_pin_oe_out));
    c_irq: cover property ($fell(irq_out));
    c_lp: cover property ($rose(low_power_out));
endmodule : wake_ctl_props
bind polling_motion_wake_control wake_ctl_props #(.ON_CYCLES_P(ON_CYCLES_P)) props_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .psel(psel), .pwrite(pwrite), .csn_in(csn_in),
    .vdd_por_in(vdd_por_in), .agc_in(agc_in), .field_strong_in(field_strong_in), .field_weak_in(field_weak_in),
    .wake_pin_out(wake_pin_out), .wake_pin_oe_out(wake_pin_oe_out), .sdo_oe_out(sdo_oe_out),
    .low_power_out(low_power_out),
    .agc_out(agc_out), .irq_out(irq_out));

// file: testbench/host_link_model.sv
// Host side of the serial link: one command frame out, reply in
`timescale 1ns/100ps
module host_link_model (
    output logic sclk_out, // Link clock, still between frames
    output logic csn_out, // Frame select
    output logic sdi_out, // Data to device
    input wire logic sdo_in // Data from device
);
    initial begin
        sclk_out = 1'b0;
        csn_out = 1'b1;
        sdi_out = 1'b0;
    end
    // Offset keeps link edges off the block's clock edges
    task automatic frame(input logic [15:0] word, output logic [15:0] got);
        got = 16'h0000;
        #7;
        csn_out = 1'b0;
        sdi_out = word[15];
        #160;
        for (int i = 15; i >= 0; i--) begin
            sclk_out = 1'b1;
            #80;
            got[i] = sdo_in;
            sclk_out = 1'b0;
            if (i > 0) sdi_out = word[i-1];
            #80;
        end
        // Released data line flips so stale bits never look valid
        csn_out = 1'b1;
        sdi_out = ~sdi_out;
        #320;
    endtask : frame
endmodule : host_link_model

// file: testbench/testbench.sv
// Self-checking bench: APB, serial host, supply cycling, wake pulse
`timescale 1ns/100ps
module testbench;
    import wake_pkg::*;
    localparam int ON_P = 50;
    localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, sclk, csn, sdi, sdo_out, sdo_oe_out, wake_pin;
    logic vdd_por_in = 1'b0;
    logic [ANGLE_W-1:0] angle_in = 8'h00;
    logic [AGC_W-1:0] agc_in = 6'h00;
    logic [AGC_W-1:0] agc_out;
    logic field_strong_in = 1'b0;
    logic field_weak_in = 1'b0;
    logic lock_in = 1'b0;
    logic [TRIM_W-1:0] fuse_in = 9'h000;
    logic wake_pin_out, wake_pin_oe_out, low_power_out, irq_out;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [32:0] e, m;
    logic [31:0] lfsr = 32'h0000_826F;
    logic [15:0] rx;
    logic [7:0] ang, ang2, trim;
    int err_total = 0;
    int checked = 0;
    always #10 clk_in = ~clk_in;
    assign wake_pin = wake_pin_oe_out ? wake_pin_out : 1'b1; // Pull-up
    polling_motion_wake_control #(.ON_CYCLES_P(ON_P)) dut_u (
        .clk_in(clk_in), .resetn_in(resetn_in), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk_in(sclk), .csn_in(csn), .sdi_in(sdi), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
        .vdd_por_in(vdd_por_in), .angle_in(angle_in), .agc_in(agc_in), .field_strong_in(field_strong_in),
        .field_weak_in(field_weak_in), .lock_in(lock_in), .fuse_in(fuse_in), .wake_pin_in(wake_pin),
        .wake_pin_out(wake_pin_out), .wake_pin_oe_out(wake_pin_oe_out), .low_power_out(low_power_out),
        .agc_out(agc_out), .irq_out(irq_out));
    host_link_model host_u (.sclk_out(sclk), .csn_out(csn), .sdi_out(sdi), .sdo_in(sdo_out));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        for (int n = 0; n <= 20; n++) begin
            @(posedge clk_in);
            if (pready === 1'b1) break;
            if (n == 20) begin
                err_total++;
                close_out();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] ex, input logic [32:0] mk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Read results are judged here, oldest expectation first
    always @(posedge clk_in) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check("apb read", {pslverr, prdata} & m, e & m);
        end
    end
    task automatic pcycle(input logic [7:0] a, input logic wake_exp);
        int t0 = 0;
        int w = 0;
        @(posedge clk_in);
        vdd_por_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        angle_in <= a;
        vdd_por_in <= 1'b1;
        for (int n = 1; n < ON_P + WAKE_CYCLES + 100; n++) begin
            @(negedge clk_in);
            if (wake_pin === 1'b0) begin
                w++;
                if (t0 == 0) t0 = n;
            end
        end
        check("wake width", 33'(w), wake_exp ? 33'(WAKE_CYCLES) : 33'h0);
        if (wake_exp) check("wake onset", 33'(t0 > ON_P && t0 < ON_P + 12), 33'h1);
    endtask : pcycle
    initial begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(OFF_CFG, 33'h1, ALL);
        rd(OFF_MASK, 33'h0, ALL);
        rd(8'h14, 33'h1_0000_0000, ALL);
        $display("test registers done");
        lfsr = lfsr_next(lfsr);
        ang = lfsr[7:0];
        trim = lfsr[15:8];
        ang2 = ang - 8'h11;
        @(posedge clk_in);
        vdd_por_in <= 1'b1;
        fuse_in <= {1'b1, trim};
        angle_in <= ang;
        agc_in <= 6'h15;
        lock_in <= 1'b1;
        repeat (ON_P * 4) @(posedge clk_in);
        host_u.frame({CMD_TRIM_RELOAD, 11'h000}, rx);
        check("reply", 33'(rx), 33'({ang, 6'h15, 2'b10}));
        rd(OFF_STATUS, 33'h2, 33'h2);
        pcycle(ang, 1'b1);
        rd(OFF_STATUS, 33'h1, 33'h1);
        apb(1'b1, OFF_MASK, 32'h0000_0001);
        @(negedge clk_in);
        check("irq set", 33'(irq_out), 33'h1);
        apb(1'b1, OFF_STATUS, 32'h0000_0001);
        @(negedge clk_in);
        check("irq clear", 33'(irq_out), 33'h0);
        $display("test wake without reference done");
        host_u.frame({CMD_CUST_WRITE, 3'b000, 8'h10}, rx);
        host_u.frame({CMD_STORE_REF, 11'h000}, rx);
        rd(OFF_REF, 33'({1'b1, trim, 8'h10, ang}), ALL);
        pcycle(ang + 8'h10, 1'b0);
        pcycle(ang2, 1'b1);
        rd(OFF_REF, 33'({1'b1, trim, 8'h10, ang}), ALL);
        rd(OFF_STATE, 33'({5'b11101, 6'h15, ang2, 6'h04}), ALL);
        $display("test threshold done");
        host_u.frame({CMD_LOW_POWER, 11'h000}, rx);
        @(negedge clk_in);
        check("low power on", 33'(low_power_out), 33'h1);
        host_u.frame({CMD_ACTIVE, 11'h000}, rx);
        check("mode bit", 33'(rx[0]), 33'h1);
        @(negedge clk_in);
        check("low power off", 33'(low_power_out), 33'h0);
        repeat (ON_P * 3) @(posedge clk_in);
        $display("test modes done");
        for (int k = 0; k < 6; k++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_in);
            field_strong_in <= (k == 0);
            field_weak_in <= (k == 1);
            agc_in <= lfsr[5:0];
            repeat (3) @(negedge clk_in);
            check("agc", 33'(agc_out), 33'((k == 0) ? AGC_MIN : (k == 1) ? AGC_MAX : lfsr[5:0]));
            if (k < 2) begin
                host_u.frame({CMD_ACTIVE, 11'h000}, rx);
                // Magnet held still, so the host takes single samples
                check("angle kept", 33'(rx[15:8]), 33'(ang2));
            end
        end
        $display("test gain done");
        lfsr = lfsr_next(lfsr);
        trim = lfsr[7:0];
        @(posedge clk_in);
        fuse_in <= {1'b0, trim};
        host_u.frame({CMD_TRIM_RELOAD, 11'h000}, rx);
        host_u.frame({CMD_STORE_REF, 11'h000}, rx);
        rd(OFF_REF, 33'({1'b0, trim, 8'h10, ang}), ALL);
        pcycle(ang + 8'h80, 1'b0);
        $display("test wake disabled done");
        close_out();
    end
    initial begin
        #500_000;
        err_total++;
        close_out();
    end
endmodule : testbench
